/* File: hdl/ifb_fetch_unit.v */
`timescale 1ns/1ps
`include "ifb_consts.vh"
module ifb_fetch_unit (
	input wire i_mclk, // Machine clock
	input wire i_reset, // Async reset, active high
	input wire i_ic_load, // Load new instruction counter
	input wire [23:0] i_ic_value, // New counter value
	input wire i_advance, // Prep op consumed, step counter
	input wire i_ie_instr, // Instruction runs in internal execution unit
	input wire i_exec_first, // First execute cycle
	input wire i_y_dec, // Decrement first length counter
	input wire i_z_dec, // Decrement second length counter
	input wire i_opnd_req, // Operand fetch request
	input wire [23:0] i_base, // Operand base register
	input wire [23:0] i_index, // Operand index register
	input wire i_sb_ready, // Storage bus control takes request
	input wire i_ret_valid, // Storage return latch holds a word
	input wire [71:0] i_ret_data, // Returned double word
	input wire i_ret_route, // Route register of the return (0=X,1=Y)
	output reg o_sb_req, // Storage request valid
	output reg [20:0] o_sb_addr, // Double-word address to storage
	output reg o_sb_route, // Route register used (0=X,1=Y)
	output reg o_opnd_valid, // Operand double word ready
	output reg [71:0] o_opnd_data, // Operand double word
	output reg o_prep_valid, // Prep op register holds two valid halfwords
	output reg [31:0] o_prep_op, // Prep op register
	output reg [15:0] o_branch_op, // Branch-unit op register
	output reg [15:0] o_exec_op, // Execute op register
	output reg [15:0] o_last_op, // Last-cycle op register
	output reg [3:0] o_putaway, // Put-away field register
	output reg [3:0] o_len1, // First length counter
	output reg [3:0] o_len2, // Second length counter
	output reg [23:0] o_ic // Instruction counter
);
	reg [71:0] buf_a;
	reg [71:0] buf_b;
	reg val_a;
	reg val_b;
	reg fill_a; // A fetch in flight
	reg fill_b;
	reg [23:0] ic;
	reg [23:0] holder; // storage_address_holder
	reg holder_full;
	reg [1:0] route_x; // Route register X destination
	reg [1:0] route_y;
	reg busy_x;
	reg busy_y;
	reg next_route; // Which route register is next
	reg last_was_ic; // Previous cycle issued an IC fetch
	reg [23:0] last_fetch;
	wire [23:0] eff_addr;
	wire [2:0] halfword_gate_selector;
	wire [15:0] hw0;
	wire [15:0] hw1;
	wire [2:0] ilen;
	wire [3:0] gsr_sum;
	wire cur_in_b;
	wire opnd_take;
	wire [73:0] fifo_out;
	wire fifo_valid;
	wire fifo_ready;
	wire fifo_out_valid;
	reg [2:0] next_hw;
	reg want_fetch;
	reg [23:0] next_fetch;

	// Pick a halfword out of the A-B ring by slot number
	function [15:0] ring_hw;
		input [2:0] slot;
		input [71:0] a;
		input [71:0] b;
		reg [71:0] w;
		begin
			w = slot[2] ? b : a;
			case (slot[1:0])
			2'h0: ring_hw = w[71:56];
			2'h1: ring_hw = w[55:40];
			2'h2: ring_hw = w[39:24];
			default: ring_hw = w[23:8];
			endcase
		end
	endfunction

	// Data bits 63:0 sit in 71:8, parity byte in 7:0
	assign halfword_gate_selector = ic[`IFB_ADDR_BIT20_POS:1];
	assign hw0 = ring_hw(halfword_gate_selector, buf_a, buf_b);
	assign hw1 = ring_hw(halfword_gate_selector + 3'h1, buf_a, buf_b);
	// Length code from the op code's top two bits
	assign ilen = (o_prep_op[31:30] == 2'h0) ? 3'h1 : (o_prep_op[31:30] == 2'h3) ? 3'h3 : 3'h2;
	assign gsr_sum = {1'b0, halfword_gate_selector} + {1'b0, ilen};
	assign cur_in_b = halfword_gate_selector[2];

	ifb_addr_adder u_adder (
		.i_base(i_base),
		.i_index(i_index),
		.i_disp(o_prep_op[11:0]),
		.o_sum(eff_addr)
	);

	// Returns queue here; the head is taken every cycle and the full flag is unused, so storage bus control is never stalled
	ifb_fifo #(
		.WIDTH(74),
		.DEPTH(`IFB_FIFO_DEPTH),
		.AW(`IFB_FIFO_AW)
	) u_ret_fifo (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_valid(i_ret_valid),
		.i_data({i_ret_route, 1'b0, i_ret_data}),
		.o_ready(fifo_ready),
		.o_valid(fifo_out_valid),
		.o_data(fifo_out),
		.i_ready(1'b1)
	);
	assign fifo_valid = fifo_out_valid;

	// Fetch decision: which buffer is empty and what increment applies
	always @* begin
		want_fetch = 1'b0;
		next_fetch = ic + `IFB_INCR_8;
		next_hw = 3'h0;
		if (!(cur_in_b ? val_b : val_a) && !(cur_in_b ? fill_b : fill_a)) begin
			// After a counter load the current double word itself is missing
			want_fetch = 1'b1;
			next_fetch = ic;
		end else if (!(cur_in_b ? val_a : val_b) && !(cur_in_b ? fill_a : fill_b)) begin
			// The counter has already stepped past the emptied buffer, so plus 8
			// here lands where plus 16 from its last instruction would
			want_fetch = 1'b1;
			next_fetch = ic + `IFB_INCR_8;
		end
		next_hw = next_fetch[`IFB_ADDR_BIT20_POS:1];
	end

	assign opnd_take = i_opnd_req && !want_fetch;

	// Address holder, route registers and request issue
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			holder <= `IFB_IC_RESET;
			holder_full <= 1'b0;
			route_x <= `IFB_ROUTE_A;
			route_y <= `IFB_ROUTE_A;
			busy_x <= 1'b0;
			busy_y <= 1'b0;
			next_route <= 1'b0;
			fill_a <= 1'b0;
			fill_b <= 1'b0;
			last_was_ic <= 1'b0;
			last_fetch <= `IFB_IC_RESET;
			o_sb_req <= 1'b0;
			o_sb_addr <= 21'h000000;
			o_sb_route <= 1'b0;
		end else begin
			last_was_ic <= 1'b0;
			if (o_sb_req && i_sb_ready)
				o_sb_req <= 1'b0;
			// Returns free their route register; set by a new issue wins below
			if (fifo_valid && !fifo_out[73])
				busy_x <= 1'b0;
			if (fifo_valid && fifo_out[73])
				busy_y <= 1'b0;
			if (fifo_valid) begin
				if ((fifo_out[73] ? route_y : route_x) == `IFB_ROUTE_A)
					fill_a <= 1'b0;
				if ((fifo_out[73] ? route_y : route_x) == `IFB_ROUTE_B)
					fill_b <= 1'b0;
			end
			// Returns come back in order, so the next route register must itself be free
			if ((!o_sb_req || i_sb_ready) && !(next_route ? busy_y : busy_x) && !i_ic_load) begin
				if (want_fetch || opnd_take) begin
					holder <= want_fetch ? next_fetch : eff_addr;
					o_sb_addr <= want_fetch ? next_fetch[23:3] : eff_addr[23:3];
					o_sb_req <= 1'b1;
					o_sb_route <= next_route;
					next_route <= ~next_route;
					if (next_route) begin
						busy_y <= 1'b1;
						route_y <= want_fetch ? {1'b0, next_fetch[3]} : `IFB_ROUTE_OPND;
					end else begin
						busy_x <= 1'b1;
						route_x <= want_fetch ? {1'b0, next_fetch[3]} : `IFB_ROUTE_OPND;
					end
					if (want_fetch && next_fetch[3])
						fill_b <= 1'b1;
					if (want_fetch && !next_fetch[3])
						fill_a <= 1'b1;
					last_was_ic <= want_fetch;
					last_fetch <= next_fetch;
				end
			end
			holder_full <= o_sb_req;
			// A new counter makes in-flight instruction words stale: drop them on return
			if (i_ic_load) begin
				fill_a <= 1'b0;
				fill_b <= 1'b0;
				if (route_x != `IFB_ROUTE_OPND)
					route_x <= `IFB_ROUTE_DROP;
				if (route_y != `IFB_ROUTE_OPND)
					route_y <= `IFB_ROUTE_DROP;
			end
		end
	end

	// Steer returns from the storage return latch by route register
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			buf_a <= 72'h0;
			buf_b <= 72'h0;
			val_a <= 1'b0;
			val_b <= 1'b0;
			o_opnd_valid <= 1'b0;
			o_opnd_data <= 72'h0;
		end else begin
			o_opnd_valid <= 1'b0;
			if (fifo_valid) begin
				case (fifo_out[73] ? route_y : route_x)
				`IFB_ROUTE_A: begin
					buf_a <= fifo_out[71:0];
					val_a <= 1'b1;
				end
				`IFB_ROUTE_B: begin
					buf_b <= fifo_out[71:0];
					val_b <= 1'b1;
				end
				`IFB_ROUTE_OPND: begin
					o_opnd_data <= fifo_out[71:0];
					o_opnd_valid <= 1'b1;
				end
				default: begin
					// Stale instruction word after a counter load is discarded
					o_opnd_valid <= 1'b0;
				end
				endcase
			end
			// Leaving a buffer empties it
			if (i_advance && o_prep_valid && gsr_sum[2] != halfword_gate_selector[2]) begin
				if (halfword_gate_selector[2])
					val_b <= 1'b0;
				else
					val_a <= 1'b0;
			end
			if (i_ic_load) begin
				val_a <= 1'b0;
				val_b <= 1'b0;
			end
		end
	end

	// Counter update through the gate selector; carry adds into bit 19
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			ic <= `IFB_IC_RESET;
			o_ic <= `IFB_IC_RESET;
		end else if (i_ic_load) begin
			ic <= {i_ic_value[23:1], 1'b0};
			o_ic <= {i_ic_value[23:1], 1'b0};
		end else if (i_advance && o_prep_valid) begin
			if (gsr_sum[3]) begin
				ic <= {ic[23:4] + 20'h00001, gsr_sum[2:0], 1'b0};
				o_ic <= {ic[23:4] + 20'h00001, gsr_sum[2:0], 1'b0};
			end else begin
				ic <= {ic[23:4], gsr_sum[2:0], 1'b0};
				o_ic <= {ic[23:4], gsr_sum[2:0], 1'b0};
			end
		end
	end

	// Op registers load from the prep op register; the last-cycle op register loads from the execute op register
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_prep_op <= 32'h0;
			o_prep_valid <= 1'b0;
			o_branch_op <= 16'h0;
			o_exec_op <= 16'h0;
			o_last_op <= 16'h0;
			o_putaway <= 4'h0;
			o_len1 <= 4'h0;
			o_len2 <= 4'h0;
		end else begin
			o_prep_op <= {hw0, hw1};
			// A consumed op must not be offered again before the counter settles
			o_prep_valid <= (halfword_gate_selector[2] ? val_b : val_a) && ((halfword_gate_selector + 3'h1) < 3'h4 ? val_a : val_b) && !i_ic_load &&
				!(i_advance && o_prep_valid);
			if (i_advance && o_prep_valid) begin
				if (i_ie_instr)
					o_branch_op <= o_prep_op[31:16];
				else
					o_exec_op <= o_prep_op[31:16];
				o_putaway <= o_prep_op[`IFB_R1_MSB:20];
				o_len1 <= o_prep_op[`IFB_L1_MSB:20];
				o_len2 <= o_prep_op[`IFB_L2_MSB:16];
			end else begin
				if (i_y_dec && o_len1 != 4'h0)
					o_len1 <= o_len1 - 4'h1;
				if (i_z_dec && o_len2 != 4'h0)
					o_len2 <= o_len2 - 4'h1;
			end
			if (i_exec_first)
				o_last_op <= o_exec_op;
		end
	end
endmodule // ifb_fetch_unit

/* File: shared/ifb_consts.vh */
`ifndef IFB_CONSTS_VH
`define IFB_CONSTS_VH
// Widths of the data paths and addresses
`define IFB_DW_WIDTH 72
`define IFB_ADDR_WIDTH 24
`define IFB_TAG_WIDTH 2
// Bit positions of the big-endian numbered address (bit 0 is the MSB)
`define IFB_ADDR_BIT20_POS 3
`define IFB_ADDR_BIT19_POS 4
`define IFB_ADDR_BIT23_POS 0
`define IFB_GSR_LSB 1
// Increments for the instruction-fetch address
`define IFB_INCR_8 24'h000008
`define IFB_INCR_16 24'h000010
`define IFB_INCR_BIT19 24'h000010
// Return route codes
`define IFB_ROUTE_A 2'h0
`define IFB_ROUTE_B 2'h1
`define IFB_ROUTE_OPND 2'h2
`define IFB_ROUTE_DROP 2'h3
// Reset values
`define IFB_IC_RESET 24'h000000
// Fields of the 32-bit op word seen on the prep op register
`define IFB_LEN_MSB 31
`define IFB_R1_MSB 23
`define IFB_L1_MSB 23
`define IFB_L2_MSB 19
// Buffering
`define IFB_FIFO_DEPTH 8
`define IFB_FIFO_AW 3
`endif

/* File: hdl/ifb_fifo.v */
`timescale 1ns/1ps
`include "ifb_consts.vh"
module ifb_fifo #(
	parameter WIDTH = 74,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire i_mclk, // Machine clock
	input wire i_reset, // Async reset
	input wire i_valid, // Write valid
	input wire [WIDTH-1:0] i_data, // Write data
	output wire o_ready, // Not full
	output wire o_valid, // Not empty
	output wire [WIDTH-1:0] o_data, // Head word
	input wire i_ready // Reader takes head
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	assign push = i_valid && (count != DEPTH);
	assign pop = i_ready && (count != 0);
	assign o_ready = (count != DEPTH);
	assign o_valid = (count != 0);
	assign o_data = mem[rd_ptr];
	// Storage array carries no reset; only pointers and occupancy count need one
	always @(posedge i_mclk) begin
		if (push)
			mem[wr_ptr] <= i_data;
	end
	// Pointers and occupancy
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // ifb_fifo

/* File: hdl/ifb_addr_adder.v */
`timescale 1ns/1ps
`include "ifb_consts.vh"
module ifb_addr_adder (
	input wire [23:0] i_base, // Base register value
	input wire [23:0] i_index, // Index register value
	input wire [11:0] i_disp, // Displacement field
	output wire [23:0] o_sum // Effective address
);
	// Three-input add in one cycle, wraps at 24 bits
	assign o_sum = i_base + i_index + {12'h000, i_disp};
endmodule // ifb_addr_adder

/* File: tb/ifb_fetch_unit_asserts.sv */
`timescale 1ns/1ps
module ifb_fetch_unit_chk (
	input wire i_mclk, // Clock
	input wire i_reset, // Reset
	input wire i_ic_load, // Load
	input wire [23:0] i_ic_value, // Value
	input wire i_advance, // Step
	input wire i_ie_instr, // To branch op
	input wire i_exec_first, // First cycle
	input wire i_y_dec, // Dec len1
	input wire i_sb_ready, // Taken
	input wire i_ret_valid, // Return
	input wire o_sb_req, // Request
	input wire [20:0] o_sb_addr, // Address
	input wire o_sb_route, // Route
	input wire o_prep_valid, // Prep valid
	input wire [31:0] o_prep_op, // Prep op
	input wire [15:0] o_branch_op, // Branch op
	input wire [15:0] o_exec_op, // Exec op
	input wire [15:0] o_last_op, // Last op
	input wire [3:0] o_len1, // Len1
	input wire [23:0] o_ic // Counter
);
	reg [1:0] busy;
	reg last_r;
	reg seen;
	wire acc = o_sb_req && i_sb_ready;
	wire [2:0] nb = (o_prep_op[31:30] == 2'h0) ? 3'h2 : (o_prep_op[31:30] == 2'h3) ? 3'h6 : 3'h4;
	// Outstanding requests, counted on the bus itself
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			busy <= 2'h0;
			seen <= 1'b0;
			last_r <= 1'b0;
		end else begin
			busy <= busy + {1'b0, acc} - {1'b0, i_ret_valid};
			if (acc) begin
				seen <= 1'b1;
				last_r <= o_sb_route;
			end
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	property p_hold;
		o_sb_req && !i_sb_ready && !i_ic_load |=> o_sb_req && $stable(o_sb_addr) && $stable(o_sb_route);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_alt;
		acc && seen |-> o_sb_route != last_r;
	endproperty
	a_alt: assert property (p_alt) else $error("route not alternated");
	property p_two;
		acc |-> busy < 2'h2 || i_ret_valid;
	endproperty
	a_two: assert property (p_two) else $error("third request outstanding");
	property p_hw;
		!o_ic[0];
	endproperty
	a_hw: assert property (p_hw) else $error("odd counter");
	property p_load;
		i_ic_load |=> o_ic == {$past(i_ic_value[23:1]), 1'b0};
	endproperty
	a_load: assert property (p_load) else $error("counter load wrong");
	property p_step;
		i_advance && o_prep_valid && !i_ic_load |=> o_ic == $past(o_ic) + {21'h0, $past(nb)};
	endproperty
	a_step: assert property (p_step) else $error("counter step wrong");
	property p_bop;
		i_advance && o_prep_valid && i_ie_instr |=> o_branch_op == $past(o_prep_op[31:16]);
	endproperty
	a_bop: assert property (p_bop) else $error("branch op wrong");
	property p_eop;
		i_advance && o_prep_valid && !i_ie_instr |=> o_exec_op == $past(o_prep_op[31:16]);
	endproperty
	a_eop: assert property (p_eop) else $error("exec op wrong");
	property p_last_cycle_op_register;
		i_exec_first |=> o_last_op == $past(o_exec_op);
	endproperty
	a_last_cycle_op_register: assert property (p_last_cycle_op_register) else $error("last op wrong");
	property p_ydec;
		i_y_dec && !i_advance && o_len1 != 4'h0 |=> o_len1 == $past(o_len1) - 4'h1;
	endproperty
	a_ydec: assert property (p_ydec) else $error("len1 not decremented");
	c_acc: cover property (acc && o_sb_route);
	c_adv: cover property (i_advance && o_prep_valid);
	c_dec: cover property (i_y_dec);
endmodule // ifb_fetch_unit_chk
bind ifb_fetch_unit ifb_fetch_unit_chk chk_i (.i_mclk, .i_reset, .i_ic_load, .i_ic_value, .i_advance, .i_ie_instr,
	.i_exec_first, .i_y_dec, .i_sb_ready, .i_ret_valid, .o_sb_req, .o_sb_addr, .o_sb_route, .o_prep_valid,
	.o_prep_op, .o_branch_op, .o_exec_op, .o_last_op, .o_len1, .o_ic);

/* File: tb/ifb_storage_model.sv */
`timescale 1ns/1ps
module ifb_storage_model (
	input wire i_mclk, // Clock
	input wire i_reset, // Reset
	input wire i_slow, // Stall mode
	input wire i_req, // Request
	input wire [20:0] i_addr, // Double word
	input wire i_route, // Route
	output wire o_ready, // Taken
	output reg o_ret_valid, // Return
	output reg [71:0] o_ret_data, // Data
	output reg o_ret_route // Route
);
	reg ph;
	reg [3:0] age;
	reg [21:0] q[$];
	function [15:0] hw(input [23:0] a);
		hw = {a[2:1], a[14:1]};
	endfunction
	function [71:0] dw(input [20:0] d);
		dw = {hw({d, 3'h0}), hw({d, 3'h2}), hw({d, 3'h4}), hw({d, 3'h6}), 8'h00};
	endfunction
	// Slow mode refuses every other cycle
	assign o_ready = !i_slow || ph;
	// In-order returns; idle data inverts so stale words never match
	always @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			q.delete();
			ph <= 1'b0;
			age <= 4'h0;
			o_ret_valid <= 1'b0;
			o_ret_data <= 72'h0;
			o_ret_route <= 1'b0;
		end else begin
			ph <= !ph;
			o_ret_valid <= 1'b0;
			o_ret_data <= ~o_ret_data;
			if (q.size() > 0 && age >= (i_slow ? 4'h6 : 4'h1)) begin
				o_ret_valid <= 1'b1;
				o_ret_data <= dw(q[0][21:1]);
				o_ret_route <= q[0][0];
				void'(q.pop_front());
				age <= 4'h0;
			end else if (q.size() > 0) begin
				age <= age + 4'h1;
			end
			if (i_req && o_ready) begin
				q.push_back({i_addr, i_route});
			end
		end
	end
endmodule // ifb_storage_model

/* File: tb/ifb_fetch_unit_tb_top.sv */
`timescale 1ns/1ps
module ifb_fetch_unit_tb_top;
	reg i_mclk = 1'b0;
	reg i_reset = 1'b1;
	reg i_ic_load = 1'b0;
	reg [23:0] i_ic_value = 24'h0;
	reg i_advance = 1'b0;
	reg i_ie_instr = 1'b0;
	reg i_exec_first = 1'b0;
	reg i_y_dec = 1'b0;
	reg i_z_dec = 1'b0;
	reg i_opnd_req = 1'b0;
	reg [23:0] i_base = 24'h0;
	reg [23:0] i_index = 24'h0;
	reg slow = 1'b0;
	wire i_sb_ready, i_ret_valid, i_ret_route, o_sb_req, o_sb_route, o_opnd_valid, o_prep_valid;
	wire [71:0] i_ret_data, o_opnd_data;
	wire [20:0] o_sb_addr;
	wire [31:0] o_prep_op;
	wire [15:0] o_branch_op, o_exec_op, o_last_op;
	wire [3:0] o_putaway, o_len1, o_len2;
	wire [23:0] o_ic;
	integer fails = 0;
	integer n_tests = 0;
	integer cyc = 0;
	reg [23:0] ic;
	ifb_fetch_unit uut (.i_mclk, .i_reset, .i_ic_load, .i_ic_value, .i_advance, .i_ie_instr, .i_exec_first,
		.i_y_dec, .i_z_dec, .i_opnd_req, .i_base, .i_index, .i_sb_ready, .i_ret_valid, .i_ret_data, .i_ret_route,
		.o_sb_req, .o_sb_addr, .o_sb_route, .o_opnd_valid, .o_opnd_data, .o_prep_valid, .o_prep_op, .o_branch_op,
		.o_exec_op, .o_last_op, .o_putaway, .o_len1, .o_len2, .o_ic);
	ifb_storage_model sm (.i_mclk, .i_reset, .i_slow(slow), .i_req(o_sb_req), .i_addr(o_sb_addr),
		.i_route(o_sb_route), .o_ready(i_sb_ready), .o_ret_valid(i_ret_valid), .o_ret_data(i_ret_data),
		.o_ret_route(i_ret_route));
	// Clock and a hang guard well above the expected run
	always #5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			summarize;
		end
	end
	task chk(input [71:0] got, input [71:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wait_prep;
		integer k;
		begin
			k = 0;
			while (o_prep_valid !== 1'b1 && k < 300) begin
				@(negedge i_mclk);
				k = k + 1;
			end
			chk(o_prep_valid, 1'b1);
		end
	endtask
	task load(input [23:0] v);
		begin
			@(negedge i_mclk);
			i_ic_load = 1'b1;
			i_ic_value = v;
			@(negedge i_mclk);
			i_ic_load = 1'b0;
			ic = {v[23:1], 1'b0};
			chk(o_ic, ic);
		end
	endtask
	// Check the gated pair, then consume it
	task step(input ie);
		reg [31:0] op;
		begin
			wait_prep;
			op = {sm.hw(ic), sm.hw(ic + 24'h2)};
			chk(o_prep_op, op);
			i_ie_instr = ie;
			i_advance = 1'b1;
			@(negedge i_mclk);
			i_advance = 1'b0;
			ic = ic + ((op[31:30] == 2'h0) ? 24'h2 : (op[31:30] == 2'h3) ? 24'h6 : 24'h4);
			chk(o_ic, ic);
			chk(ie ? o_branch_op : o_exec_op, op[31:16]);
		end
	endtask
	task t_stream;
		integer i;
		begin
			load(24'h001001);
			for (i = 0; i < 20; i = i + 1) begin
				slow = (i >= 10);
				step(i[0]);
			end
			slow = 1'b0;
			$display("stream test done");
		end
	endtask
	// Start on the last halfword of an odd word so the pair wraps
	task t_wrap;
		begin
			load(24'h00020E);
			slow = 1'b1;
			repeat (6) step(1'b0);
			slow = 1'b0;
			$display("wrap test done");
		end
	endtask
	task t_len;
		reg [31:0] op;
		begin
			op = {sm.hw(ic), sm.hw(ic + 24'h2)};
			step(1'b0);
			chk(o_putaway, op[23:20]);
			chk(o_len2, op[19:16]);
			i_y_dec = 1'b1;
			i_z_dec = 1'b1;
			@(negedge i_mclk);
			i_y_dec = 1'b0;
			i_z_dec = 1'b0;
			chk(o_len1, (op[23:20] == 4'h0) ? 4'h0 : op[23:20] - 4'h1);
			chk(o_len2, (op[19:16] == 4'h0) ? 4'h0 : op[19:16] - 4'h1);
			i_exec_first = 1'b1;
			@(negedge i_mclk);
			i_exec_first = 1'b0;
			chk(o_last_op, op[31:16]);
			$display("length test done");
		end
	endtask
	task t_opnd;
		reg [15:0] h;
		reg [23:0] ea;
		integer k;
		begin
			wait_prep;
			h = sm.hw(ic + 24'h2);
			i_base = 24'h000340;
			i_index = 24'h000028;
			ea = 24'h000368 + {12'h0, h[11:0]};
			i_opnd_req = 1'b1;
			k = 0;
			while (o_opnd_valid !== 1'b1 && k < 300) begin
				@(negedge i_mclk);
				k = k + 1;
			end
			i_opnd_req = 1'b0;
			chk(o_opnd_data, sm.dw(ea[23:3]));
			$display("operand test done");
		end
	endtask
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(negedge i_mclk);
		i_reset = 1'b0;
		t_stream;
		t_wrap;
		t_len;
		t_opnd;
		summarize;
	end
endmodule // ifb_fetch_unit_tb_top
